/* shared/via_pkg.sv */
// constants shared by the vectored interrupt arbiter
`default_nettype none
package via_pkg;
	// ****************************************
	// sizes and addresses
	// ****************************************
	localparam int          NUM_SRC      = 11;     // maskable sources
	localparam int          NUM_POS      = 16;     // vector table slots
	localparam int          PC_W         = 15;     // program address width
	localparam int          TRAP_POS     = 15;     // trap slot, top rank
	localparam int          DEFAULT_POS  = 0;      // default vector slot
	localparam logic [14:0] ENTRY_ADDR   = 15'h00ff;
	localparam logic [7:0]  VEC_BASE     = 8'he0;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [10:0] PEND_RST     = 11'h000;
	localparam logic [10:0] EN_RST       = 11'h000;
	localparam logic        GIE_RST      = 1'b0;
	localparam logic        TRAP_RST     = 1'b0;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS  = 4;
	localparam int INSTR_CYCLE_NS = 1000;      // one instruction cycle
	localparam int ACK_INSTR      = 7;         // acknowledge length
	localparam int ACK_CYC        =
		(ACK_INSTR * INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W          = 12;

	// ****************************************
	// slot of each maskable source, lowest rank first
	// ****************************************
	localparam logic [3:0] SRC_POS [NUM_SRC] = '{
		4'h1, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he
	};
endpackage : via_pkg
`default_nettype wire

/* verilog/via_vec_enc.sv */
// picks the highest active vector slot and forms its low byte
`default_nettype none
`timescale 1ns/1ps
module via_vec_enc #(
	parameter int NUM_POS = 16
) (
	input  wire logic [NUM_POS-1:0] active_in,
	output logic      [7:0]         code_out,
	output logic                    any_out
);
	logic [3:0] top_idx;

	// scan upward so the highest slot wins; none active leaves slot 0
	always_comb begin
		top_idx = 4'h0;
		for (int i = 0; i < NUM_POS; i++) begin
			if (active_in[i]) begin
				top_idx = 4'(i);
			end
		end
	end

	// slot n sits at base plus 2n, always an even byte
	assign code_out = via_pkg::VEC_BASE + {3'h0, top_idx, 1'b0};
	assign any_out  = |active_in;
endmodule // via_vec_enc
`default_nettype wire

/* verilog/via_arbiter.sv */
// vectored interrupt arbiter: flags, acceptance and acknowledge sequence
`default_nettype none
`timescale 1ns/1ps
// What this block does
// - every accepted interrupt jumps to 00ff
// - trap ranks highest, default vector lowest
// - eleven maskable inputs with fixed rank, slot
// - each maskable source has enable and pending
// - event sets pending regardless of enable
// - maskable take needs enable, global enable, no trap
// - accept only at instruction start
// - highest ranked qualifying request served first
// - reset clears pending, enables, global enable
// - enabling set pending triggers at once
// - finish a pending skip before acknowledging
// - acknowledge start clears global enable
// - acknowledge pushes next instruction address
// - acknowledge ends loading counter with 00ff
// - acknowledge lasts seven instruction cycles
// - software may set global enable to nest
// - return sets global enable, restores address
// - pending request served right after return
// - flags and enables are software accessible
// - vector select gives even byte e0..fe
// - nothing active selects the e0 slot
module via_arbiter #(
	parameter int NUM_SRC = via_pkg::NUM_SRC,
	parameter int ACK_CYC = via_pkg::ACK_CYC
) (
	input  wire logic                      clk_in,
	input  wire logic                      reset_n_in,
	// peripheral events, one-cycle pulses on this clock
	input  wire logic [NUM_SRC-1:0]        src_event_in,
	input  wire logic                      sw_trap_in,
	// software access to flags and enables
	input  wire logic                      pend_wr_in,
	input  wire logic [NUM_SRC-1:0]        pend_wdata_in,
	input  wire logic                      en_wr_in,
	input  wire logic [NUM_SRC-1:0]        en_wdata_in,
	input  wire logic                      gie_wr_in,
	input  wire logic                      gie_wdata_in,
	output logic      [NUM_SRC-1:0]        pend_out,
	output logic      [NUM_SRC-1:0]        en_out,
	output logic                           global_irq_enable_out,
	// instruction sequencer
	input  wire logic                      instr_start_in,
	input  wire logic                      skip_next_in,
	input  wire logic [via_pkg::PC_W-1:0]  program_counter_in,
	input  wire logic                      vis_in,
	input  wire logic                      return_from_irq_instruction_in,
	input  wire logic [via_pkg::PC_W-1:0]  pop_data_in,
	output logic                           irq_take_out,
	output logic                           ack_busy_out,
	output logic                           push_out,
	output logic      [via_pkg::PC_W-1:0]  push_data_out,
	output logic                           pop_out,
	output logic                           pc_load_out,
	output logic      [via_pkg::PC_W-1:0]  pc_load_data_out,
	output logic                           vis_default_out,
	output logic                           trap_busy_out,
	output logic                           irq_active_out
);
	// ****************************************
	// state and signals
	// ****************************************
	typedef enum logic [1:0] {
		VIA_IDLE,
		VIA_ACK,
		VIA_LOAD
	} via_state_e;

	localparam logic [via_pkg::CNT_W-1:0] ACK_LAST =
		via_pkg::CNT_W'(ACK_CYC - 2);

	via_state_e                    state_reg;
	via_state_e                    state_next;
	logic [via_pkg::CNT_W-1:0]     cnt_reg;
	logic [via_pkg::CNT_W-1:0]     cnt_next;
	logic [NUM_SRC-1:0]            pend_reg;
	logic [NUM_SRC-1:0]            pend_next;
	logic [NUM_SRC-1:0]            en_reg;
	logic [NUM_SRC-1:0]            en_next;
	logic                          gie_reg;
	logic                          gie_next;
	logic                          trap_pend_reg;
	logic                          trap_pend_next;
	logic                          trap_busy_reg;
	logic                          trap_busy_next;
	logic                          push_reg;
	logic                          push_next;
	logic [via_pkg::PC_W-1:0]      push_data_reg;
	logic [via_pkg::PC_W-1:0]      push_data_next;
	logic                          pop_reg;
	logic                          pop_next;
	logic                          load_reg;
	logic                          load_next;
	logic [via_pkg::PC_W-1:0]      load_data_reg;
	logic [via_pkg::PC_W-1:0]      load_data_next;
	logic                          vis_def_reg;
	logic                          vis_def_next;

	logic [NUM_SRC-1:0]            src_active;
	logic [via_pkg::NUM_POS-1:0]   slot_active;
	logic [7:0]                    vec_code;
	logic                          any_slot;
	logic                          mask_ok;
	logic                          trap_ok;
	logic                          take;

	// ****************************************
	// arbitration
	// ****************************************
	// per source enable and pending
	assign src_active = en_reg & pend_reg;

	// spread sources over their fixed slots, trap on top
	always_comb begin
		slot_active = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			slot_active[via_pkg::SRC_POS[i]] = src_active[i];
		end
		slot_active[via_pkg::TRAP_POS] = trap_pend_reg;
	end

	// even low byte for top slot
	via_vec_enc #(
		.NUM_POS (via_pkg::NUM_POS)
	) u_vec_enc (
		.active_in (slot_active),
		.code_out  (vec_code),
		.any_out   (any_slot)
	);

	// maskable needs gie and no trap service
	assign mask_ok = (|src_active) && gie_reg && !trap_busy_reg;
	// trap ignores the global enable but not its own service
	assign trap_ok = trap_pend_reg && !trap_busy_reg;
	// decide only at an instruction start
	// a pending skip defers the acknowledge
	assign take = instr_start_in && !skip_next_in &&
		(state_reg == VIA_IDLE) && (mask_ok || trap_ok);

	// ****************************************
	// flags and enables
	// ****************************************
	// software writes first, hardware events on top
	always_comb begin
		pend_next      = pend_reg;
		en_next        = en_reg;
		gie_next       = gie_reg;
		trap_pend_next = trap_pend_reg;
		trap_busy_next = trap_busy_reg;
		if (pend_wr_in) begin
			pend_next = pend_wdata_in;
		end
		if (en_wr_in) begin
			en_next = en_wdata_in;
		end
		if (gie_wr_in) begin
			gie_next = gie_wdata_in;
		end
		if (return_from_irq_instruction_in) begin
			gie_next = 1'b1;
			// trap flag stays until its routine returns
			if (trap_busy_reg) begin
				trap_busy_next = 1'b0;
				trap_pend_next = 1'b0;
			end
		end
		if (take) begin
			gie_next = 1'b0;
			if (trap_ok) begin
				trap_busy_next = 1'b1;
			end
		end
		// events set pending, set beats clear
		pend_next = pend_next | src_event_in;
		if (sw_trap_in) begin
			trap_pend_next = 1'b1;
		end
	end

	// flag registers
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			pend_reg      <= via_pkg::PEND_RST;
			en_reg        <= via_pkg::EN_RST;
			gie_reg       <= via_pkg::GIE_RST;
			trap_pend_reg <= via_pkg::TRAP_RST;
			trap_busy_reg <= 1'b0;
		end else begin
			pend_reg      <= pend_next;
			en_reg        <= en_next;
			gie_reg       <= gie_next;
			trap_pend_reg <= trap_pend_next;
			trap_busy_reg <= trap_busy_next;
		end
	end

	// ****************************************
	// acknowledge sequence and program counter loads
	// ****************************************
	// the sequence blocks new takes, so nothing can preempt it
	always_comb begin
		state_next     = state_reg;
		cnt_next       = cnt_reg;
		push_next      = 1'b0;
		push_data_next = push_data_reg;
		pop_next       = 1'b0;
		load_next      = 1'b0;
		load_data_next = load_data_reg;
		vis_def_next   = vis_def_reg;
		case (state_reg)
			VIA_IDLE: begin
				if (take) begin
					push_next      = 1'b1;
					push_data_next = program_counter_in;
					cnt_next       = '0;
					state_next     = VIA_ACK;
				end else if (return_from_irq_instruction_in) begin
					pop_next       = 1'b1;
					load_next      = 1'b1;
					load_data_next = pop_data_in;
				end else if (vis_in) begin
					load_next      = 1'b1;
					load_data_next = {program_counter_in[14:8], vec_code};
					vis_def_next   = !any_slot;
				end
			end
			VIA_ACK: begin
				if (cnt_reg == ACK_LAST) begin
					state_next = VIA_LOAD;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			VIA_LOAD: begin
				load_next      = 1'b1;
				load_data_next = via_pkg::ENTRY_ADDR;
				state_next     = VIA_IDLE;
			end
			default: begin
				state_next = VIA_IDLE;
			end
		endcase
	end

	// sequence registers
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state_reg     <= VIA_IDLE;
			cnt_reg       <= '0;
			push_reg      <= 1'b0;
			push_data_reg <= '0;
			pop_reg       <= 1'b0;
			load_reg      <= 1'b0;
			load_data_reg <= '0;
			vis_def_reg   <= 1'b0;
		end else begin
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			push_reg      <= push_next;
			push_data_reg <= push_data_next;
			pop_reg       <= pop_next;
			load_reg      <= load_next;
			load_data_reg <= load_data_next;
			vis_def_reg   <= vis_def_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// after return the next start takes any pending one
	assign irq_take_out          = take;
	assign ack_busy_out          = (state_reg != VIA_IDLE);
	assign pend_out              = pend_reg;
	assign en_out                = en_reg;
	assign global_irq_enable_out = gie_reg;
	assign push_out              = push_reg;
	assign push_data_out         = push_data_reg;
	assign pop_out               = pop_reg;
	assign pc_load_out           = load_reg;
	assign pc_load_data_out      = load_data_reg;
	assign vis_default_out       = vis_def_reg;
	assign trap_busy_out         = trap_busy_reg;
	// live view; the sequencer may use it to wake from waits
	assign irq_active_out        = mask_ok || trap_ok;
endmodule // via_arbiter
`default_nettype wire

/* tb/via_arbiter_checker.sv */
// port assertions for the interrupt arbiter
`timescale 1ns/1ps
`default_nettype none
module via_arbiter_checker #(
	parameter int NUM_SRC = 11,
	parameter int ACK_CYC = 8
) (
	input wire logic			clk_in,
	input wire logic			reset_n_in,
	input wire logic [NUM_SRC-1:0]	src_event_in,
	input wire logic [NUM_SRC-1:0]	pend_out,
	input wire logic [NUM_SRC-1:0]	en_out,
	input wire logic			global_irq_enable_out,
	input wire logic			instr_start_in,
	input wire logic			skip_next_in,
	input wire logic [14:0]		program_counter_in,
	input wire logic			vis_in,
	input wire logic			return_from_irq_instruction_in,
	input wire logic [14:0]		pop_data_in,
	input wire logic			irq_take_out,
	input wire logic			ack_busy_out,
	input wire logic			push_out,
	input wire logic [14:0]		push_data_out,
	input wire logic			pop_out,
	input wire logic			pc_load_out,
	input wire logic [14:0]		pc_load_data_out,
	input wire logic			vis_default_out,
	input wire logic			trap_busy_out
);
	// ****
	// acknowledge and selection checks
	// ****
	// load is registered out of the last busy cycle, one beyond the count
	localparam int LOAD_DLY = ACK_CYC + 1;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// busy spans eight cycles, the whole acknowledge when ACK_CYC is 8, load cycle included
	sequence s_ack_hold;
		ack_busy_out [*8];
	endsequence
	sequence s_vis_req;
		vis_in && !ack_busy_out && !irq_take_out && !return_from_irq_instruction_in;
	endsequence
	a_take_push_next: assert property (irq_take_out |=> push_out &&
		push_data_out == $past(program_counter_in)) else $error("bad push");
	a_ack_busy_span: assert property (irq_take_out |=> s_ack_hold
		##1 !ack_busy_out) else $error("bad busy span");
	a_entry_load: assert property (irq_take_out |-> ##LOAD_DLY
		(pc_load_out && pc_load_data_out == 15'h00ff)) else $error("no entry");
	a_gie_clear_ack: assert property (irq_take_out |=>
		!global_irq_enable_out) else $error("gie kept");
	a_take_at_start: assert property (irq_take_out |->
		instr_start_in && !skip_next_in && !ack_busy_out) else $error("take");
	a_ready_is_taken: assert property (instr_start_in && !skip_next_in &&
		!ack_busy_out && global_irq_enable_out && !trap_busy_out &&
		(pend_out & en_out) != '0 |-> irq_take_out) else $error("no take");
	a_event_sets_pend: assert property (src_event_in != '0 |=>
		(pend_out & $past(src_event_in)) == $past(src_event_in))
		else $error("flag not set");
	a_return_from_irq_instruction_restore: assert property (return_from_irq_instruction_in && !ack_busy_out &&
		!irq_take_out |=> pop_out && pc_load_out && global_irq_enable_out &&
		pc_load_data_out == $past(pop_data_in)) else $error("bad return");
	a_vis_even_code: assert property (s_vis_req |=> pc_load_out &&
		!pc_load_data_out[0] && pc_load_data_out[7:5] == 3'h7 &&
		(pc_load_data_out >> 8) == ($past(program_counter_in) >> 8))
		else $error("bad vector code");
	a_vis_default: assert property (s_vis_req ##0 !trap_busy_out &&
		(pend_out & en_out) == '0 |=> pc_load_data_out[7:0] == 8'he0 &&
		vis_default_out) else $error("bad default vector");
endmodule // via_arbiter_checker
bind via_arbiter via_arbiter_checker #(.NUM_SRC(NUM_SRC), .ACK_CYC(ACK_CYC)) u_chk (
	.clk_in(clk_in), .reset_n_in(reset_n_in), .src_event_in(src_event_in),
	.pend_out(pend_out), .en_out(en_out),
	.global_irq_enable_out(global_irq_enable_out),
	.instr_start_in(instr_start_in), .skip_next_in(skip_next_in),
	.program_counter_in(program_counter_in), .vis_in(vis_in),
	.return_from_irq_instruction_in(return_from_irq_instruction_in), .pop_data_in(pop_data_in),
	.irq_take_out(irq_take_out), .ack_busy_out(ack_busy_out),
	.push_out(push_out), .push_data_out(push_data_out), .pop_out(pop_out),
	.pc_load_out(pc_load_out), .pc_load_data_out(pc_load_data_out),
	.vis_default_out(vis_default_out), .trap_busy_out(trap_busy_out));
`default_nettype wire

/* tb/via_seq_model.sv */
// instruction sequencer and stack stand-in facing the arbiter
`timescale 1ns/1ps
`default_nettype none
module via_seq_model (
	input wire logic		clk_in,
	input wire logic		reset_n_in,
	input wire logic		push_in,
	input wire logic [14:0]	push_data_in,
	input wire logic		pop_in,
	input wire logic		return_from_irq_instruction_in,
	input wire logic		pc_load_in,
	input wire logic [14:0]	pc_load_data_in,
	output logic			instr_start_out,
	output logic [14:0]		program_counter_out,
	output logic [14:0]		pop_data_out
);
	logic [1:0]	ph_reg;
	logic [2:0]	sp_reg;
	logic [14:0]	st_reg [8];
	always_ff @(posedge clk_in) begin
		ph_reg <= reset_n_in ? ph_reg + 2'h1 : 2'h0;
		instr_start_out <= reset_n_in && ph_reg == 2'h3;
		if (!reset_n_in)
			program_counter_out <= 15'h0200;
		else if (pc_load_in)
			program_counter_out <= pc_load_data_in;
		else if (instr_start_out)
			program_counter_out <= program_counter_out + 15'h1;
	end
	always_ff @(posedge clk_in) begin
		if (!reset_n_in)
			sp_reg <= 3'h0;
		else if (push_in) begin
			st_reg[sp_reg] <= push_data_in;
			sp_reg <= sp_reg + 3'h1;
		end else if (pop_in)
			sp_reg <= sp_reg - 3'h1;
	end
	// popped word only valid with the return; garbage otherwise
	assign pop_data_out = return_from_irq_instruction_in ? st_reg[sp_reg-3'h1] : ~st_reg[sp_reg-3'h1];
endmodule // via_seq_model
`default_nettype wire

/* tb/via_arbiter_bench.sv */
// self-checking bench for the interrupt arbiter
`timescale 1ns/1ps
`default_nettype none
module via_arbiter_bench;
	localparam int ACK = 8;	// short acknowledge keeps the run brief
	logic		clk_in = 1'h0, reset_n_in = 1'h0, sw_trap_in = 1'h0;
	logic [10:0]	src_event_in = '0, pend_wdata_in = '0, en_wdata_in = '0;
	logic		pend_wr_in = 1'h0, en_wr_in = 1'h0, gie_wr_in = 1'h0;
	logic		gie_wdata_in = 1'h0, skip_next_in = 1'h0;
	logic		vis_in = 1'h0, return_from_irq_instruction_in = 1'h0, instr_start_in;
	logic [14:0]	program_counter_in, pop_data_in, push_data_out;
	logic [14:0]	pc_load_data_out, ret_q [$];
	logic [10:0]	pend_out, en_out;
	logic		global_irq_enable_out, irq_take_out, ack_busy_out, push_out;
	logic		pop_out, pc_load_out, vis_default_out, trap_busy_out;
	int		n_errors = 0, checks = 0, cyc = 0, i;
	// ****
	// design, partner and clock
	// ****
	via_arbiter #(.ACK_CYC(ACK)) DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.src_event_in(src_event_in), .sw_trap_in(sw_trap_in),
		.pend_wr_in(pend_wr_in), .pend_wdata_in(pend_wdata_in),
		.en_wr_in(en_wr_in), .en_wdata_in(en_wdata_in), .gie_wr_in(gie_wr_in),
		.gie_wdata_in(gie_wdata_in), .pend_out(pend_out), .en_out(en_out),
		.global_irq_enable_out(global_irq_enable_out),
		.instr_start_in(instr_start_in), .skip_next_in(skip_next_in),
		.program_counter_in(program_counter_in), .vis_in(vis_in),
		.return_from_irq_instruction_in(return_from_irq_instruction_in), .pop_data_in(pop_data_in),
		.irq_take_out(irq_take_out), .ack_busy_out(ack_busy_out),
		.push_out(push_out), .push_data_out(push_data_out), .pop_out(pop_out),
		.pc_load_out(pc_load_out), .pc_load_data_out(pc_load_data_out),
		.vis_default_out(vis_default_out), .trap_busy_out(trap_busy_out),
		.irq_active_out());
	via_seq_model u_seq (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.push_in(push_out), .push_data_in(push_data_out), .pop_in(pop_out),
		.return_from_irq_instruction_in(return_from_irq_instruction_in), .pc_load_in(pc_load_out),
		.pc_load_data_in(pc_load_data_out), .instr_start_out(instr_start_in),
		.program_counter_out(program_counter_in), .pop_data_out(pop_data_in));
	always #2 clk_in = ~clk_in;
	// cut a hang short
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			give_verdict();
		end
	end
	task give_verdict;
		if (n_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [22:0] exp, input logic [22:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// k selects pending, enable or global enable
	task wr(input int k, input logic [10:0] v);
		@(posedge clk_in);
		pend_wdata_in <= v;
		en_wdata_in <= v;
		gie_wdata_in <= v[0];
		pend_wr_in <= (k == 0);
		en_wr_in <= (k == 1);
		gie_wr_in <= (k == 2);
		@(posedge clk_in);
		pend_wr_in <= 1'h0;
		en_wr_in <= 1'h0;
		gie_wr_in <= 1'h0;
	endtask
	task quiet;
		repeat (12) begin
			@(posedge clk_in);
			#1;
			chk("no take", 0, irq_take_out);
		end
	endtask
	// waits for a take, then for the entry load
	task serve;
		int n;
		n = 0;
		#1;
		while (irq_take_out !== 1'h1 && n < 40) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		ret_q.push_back(program_counter_in);
		for (n = 0; n < 40 && pc_load_out !== 1'h1; n++) begin
			@(posedge clk_in);
			#1;
		end
		chk("ack cycles", ACK + 1, n);
		chk("entry", 15'h00ff, pc_load_data_out);
		chk("gie", 0, global_irq_enable_out);
	endtask
	task return_from_irq_instruction;
		logic [14:0] r;
		r = ret_q.pop_back();
		@(posedge clk_in);
		return_from_irq_instruction_in <= 1'h1;
		@(posedge clk_in);
		return_from_irq_instruction_in <= 1'h0;
		#1;
		chk("return", {6'h0, 2'h3, r},
			{pop_out, global_irq_enable_out, pc_load_data_out});
	endtask
	task vector_select_instruction(input logic [7:0] code);
		@(posedge clk_in);
		vis_in <= 1'h1;
		@(posedge clk_in);
		vis_in <= 1'h0;
		#1;
		chk("vector", {1'h1, code}, {pc_load_out, pc_load_data_out[7:0]});
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		repeat (2) @(posedge clk_in);
		reset_n_in <= 1'h1;
		@(posedge clk_in);
		src_event_in <= 11'h008;
		#1;
		chk("reset", 0, {pend_out, en_out, global_irq_enable_out});
		@(posedge clk_in);
		src_event_in <= 11'h000;
		quiet();
		chk("pend", 11'h008, pend_out);
		wr(1, 11'h008);
		quiet();
		wr(2, 11'h001);
		serve();
		@(posedge clk_in);
		src_event_in <= 11'h080;
		@(posedge clk_in);
		src_event_in <= 11'h000;
		wr(1, 11'h088);
		wr(2, 11'h001);
		serve();
		wr(0, 11'h008);
		return_from_irq_instruction();
		serve();
		wr(0, 11'h000);
		return_from_irq_instruction();
		return_from_irq_instruction();
		wr(2, 11'h000);
		wr(1, 11'h7ff);
		for (i = 0; i < 11; i++) begin
			wr(0, 11'h001 << i);
			vector_select_instruction(via_pkg::VEC_BASE + {3'h0, via_pkg::SRC_POS[i], 1'h0});
		end
		wr(0, 11'h7ff);
		vector_select_instruction(via_pkg::VEC_BASE + {3'h0, via_pkg::SRC_POS[10], 1'h0});
		wr(0, 11'h000);
		vector_select_instruction(8'he0);
		chk("default", 1, vis_default_out);
		@(posedge clk_in);
		skip_next_in <= 1'h1;
		wr(0, 11'h001);
		wr(2, 11'h001);
		quiet();
		@(posedge clk_in);
		skip_next_in <= 1'h0;
		serve();
		wr(0, 11'h000);
		return_from_irq_instruction();
		wr(2, 11'h000);
		@(posedge clk_in);
		sw_trap_in <= 1'h1;
		@(posedge clk_in);
		sw_trap_in <= 1'h0;
		serve();
		vector_select_instruction(8'hfe);
		wr(0, 11'h001);
		wr(2, 11'h001);
		quiet();
		return_from_irq_instruction();
		serve();
		@(posedge clk_in);
		reset_n_in <= 1'h0;
		repeat (2) @(posedge clk_in);
		#1;
		chk("reset", 0, {pend_out, en_out, global_irq_enable_out});
		give_verdict();
	end
endmodule // via_arbiter_bench
`default_nettype wire
